// ==== hw/char_lcd_ctrl.sv ====
// Function
// - line one 00-27, line two 40-67
// - four-line panels split each logical line
// - 160 text bytes, 64 glyph bytes
// - eight glyphs small font, four large
// - codes 0x-0F pick glyph, five pixel bits
// - select low command/status, high data
// - data port follows last address command; clear and home select text memory
// - status gives busy bit7, counter low
// - clear blanks and homes; home unshifts
// - display on, cursor, blink control
// - bus width, line count, font select
// - glyph address command selects glyph memory
// - text address command selects text memory
// - data written and read via data port
`timescale 1ns/1ps
`default_nettype none
module char_lcd_ctrl
  import char_lcd_pkg::*;
#(
  parameter int VIS_COLS  = 20,
  parameter int CMD_CYC   = CMD_EXEC_CYC,
  parameter int CLEAR_CYC = CLEAR_EXEC_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_nrst,
  input  wire logic              i_e,
  input  wire logic              i_register_select,
  input  wire logic              i_rw,
  input  wire logic [DATA_W-1:0] i_bus_data,
  output var  logic [DATA_W-1:0] o_bus_data,
  output var  logic              o_bus_oe_n,
  input  wire logic [1:0]        i_scan_row,
  input  wire logic [5:0]        i_scan_col,
  input  wire logic [3:0]        i_scan_pix_row,
  output var  logic [DATA_W-1:0] o_scan_code,
  output var  logic [4:0]        o_scan_pixels,
  output var  disp_cfg_t         o_disp_cfg,
  output var  logic [AC_W-1:0]   o_cursor_addr
);

  if (VIS_COLS < 1 || VIS_COLS > LINE_COLS / 2 + LINE_COLS / 2)
    $error("VIS_COLS out of range");
  if (CLEAR_CYC <= DISP_BYTES || CLEAR_CYC >= (1 << BUSY_CNT_W))
    $error("CLEAR_CYC out of range");
  if (CMD_CYC < 1 || CMD_CYC >= (1 << BUSY_CNT_W))
    $error("CMD_CYC out of range");

  bus_pins_t          p;
  logic               e_d_r;
  logic               acc_rs_r;
  logic               acc_rw_r;
  logic               nib_r;
  logic [3:0]         hi_r;
  logic [DATA_W-1:0]  rd_byte_r;
  logic [DATA_W-1:0]  bus_out_r;
  logic               oe_n_r;
  disp_cfg_t          cfg_r;
  logic [AC_W-1:0]    ac_r;
  logic               sel_glyph_r;
  logic [5:0]         shift_r;
  exec_state_t        state_r;
  logic [BUSY_CNT_W-1:0] busy_cnt_r;
  logic [7:0]         wipe_idx_r;
  logic [DATA_W-1:0]  scan_code_r;
  logic [3:0]         scan_row_r;
  logic [4:0]         scan_pix_r;
  logic [DATA_W-1:0]  disp_mem [DISP_BYTES];
  logic [DATA_W-1:0]  glyph_mem [GLYPH_BYTES];

  logic               e_rise;
  logic               e_fall;
  logic               done;
  logic [DATA_W-1:0]  wbyte;
  logic               busy;
  logic               cmd_ok;
  logic               wr_ok;
  logic               rd_done;
  logic [DATA_W-1:0]  rd_val;
  logic [AC_W-1:0]    ac_nxt;
  logic [6:0]         scan_sum;
  logic [6:0]         scan_col;
  logic [5:0]         glyph_addr;

  pin_filter #(
    .W ($bits(bus_pins_t))
  ) u_pins (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pins    ({i_e, i_register_select, i_rw, i_bus_data}),
    .o_level   (p)
  );

  // strobe edges and transfer completion; 4-bit needs two strobes
  assign e_rise  = p.e & ~e_d_r;
  assign e_fall  = ~p.e & e_d_r;
  assign done    = e_fall & (cfg_r.bus_8bit | nib_r);
  assign wbyte   = cfg_r.bus_8bit ? p.d : {hi_r, p.d[7:4]};
  assign busy    = (state_r != ST_IDLE);
  // writes during busy are dropped; host is expected to poll first
  assign cmd_ok  = done & ~acc_rs_r & ~acc_rw_r & ~busy;
  assign wr_ok   = done & acc_rs_r & ~acc_rw_r & ~busy;
  assign rd_done = done & acc_rs_r & acc_rw_r;

  // value presented on a read: status or memory at the counter
  always_comb begin
    if (!p.register_select) begin
      rd_val = {busy, ac_r};
    end else if (sel_glyph_r) begin
      rd_val = glyph_mem[ac_r[GLYPH_AW-1:0]];
    end else begin
      rd_val = disp_mem[disp_index(ac_r)];
    end
  end

  // counter step after a data write or data read; cursor moves use ac_nxt_dir
  always_comb begin
    ac_nxt = ac_r;
    if (sel_glyph_r) begin
      ac_nxt = cfg_r.addr_inc ? {1'b0, 6'(ac_r[5:0] + 6'h01)}
                              : {1'b0, 6'(ac_r[5:0] - 6'h01)};
    end else if (cfg_r.addr_inc) begin
      if (ac_r == LINE1_LAST) ac_nxt = LINE2_FIRST;
      else if (ac_r == LINE2_LAST) ac_nxt = LINE1_FIRST;
      else ac_nxt = 7'(ac_r + 7'h01);
    end else begin
      if (ac_r == LINE1_FIRST) ac_nxt = LINE2_LAST;
      else if (ac_r == LINE2_FIRST) ac_nxt = LINE1_LAST;
      else ac_nxt = 7'(ac_r - 7'h01);
    end
  end

  // strobe tracking and nibble pairing
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      e_d_r    <= 1'b0;
      acc_rs_r <= 1'b0;
      acc_rw_r <= 1'b0;
      nib_r    <= 1'b0;
      hi_r     <= 4'h0;
    end else begin
      e_d_r <= p.e;
      if (e_rise) begin
        acc_rs_r <= p.register_select;
        acc_rw_r <= p.rw;
      end
      if (e_fall && !cfg_r.bus_8bit) begin
        nib_r <= ~nib_r;
        if (!nib_r) hi_r <= p.d[7:4];
      end else if (cfg_r.bus_8bit) begin
        nib_r <= 1'b0;
      end
    end
  end

  // read data driver; enable low only while strobe high and reading
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_byte_r <= 8'h00;
      bus_out_r <= 8'h00;
      oe_n_r    <= 1'b1;
    end else begin
      oe_n_r <= ~(p.e & p.rw);
      if (e_rise && p.rw) begin
        if (cfg_r.bus_8bit) begin
          bus_out_r <= rd_val;
        end else if (!nib_r) begin
          rd_byte_r <= rd_val;
          bus_out_r <= {rd_val[7:4], 4'h0};
        end else begin
          bus_out_r <= {rd_byte_r[3:0], 4'h0};
        end
      end
    end
  end

  // command interpreter: configuration, counter and shift
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r       <= CFG_RESET;
      ac_r        <= 7'h00;
      sel_glyph_r <= 1'b0;
      shift_r     <= 6'h00;
    end else if (cmd_ok) begin
      if (wbyte[7]) begin
        ac_r        <= wbyte[6:0];
        sel_glyph_r <= 1'b0;
      end else if (wbyte[6]) begin
        ac_r        <= {1'b0, wbyte[5:0]};
        sel_glyph_r <= 1'b1;
      end else if (wbyte[5]) begin
        cfg_r.bus_8bit   <= wbyte[4];
        cfg_r.two_line   <= wbyte[3];
        cfg_r.large_font <= wbyte[2];
      end else if (wbyte[4]) begin
        if (!wbyte[3]) ac_r <= ac_nxt_dir(wbyte[2]);
        else shift_r <= shift_step(~wbyte[2]);
      end else if (wbyte[3]) begin
        cfg_r.display_on <= wbyte[2];
        cfg_r.cursor_on  <= wbyte[1];
        cfg_r.blink_on   <= wbyte[0];
      end else if (wbyte[2]) begin
        cfg_r.addr_inc <= wbyte[1];
        cfg_r.shift_on <= wbyte[0];
      end else if (wbyte[1] || wbyte[0]) begin
        ac_r        <= 7'h00;
        sel_glyph_r <= 1'b0;
        shift_r     <= 6'h00;
        if (wbyte[0]) cfg_r.addr_inc <= 1'b1;
      end
    end else if (wr_ok || rd_done) begin
      ac_r <= ac_nxt;
      if (wr_ok && cfg_r.shift_on && !sel_glyph_r)
        shift_r <= shift_step(cfg_r.addr_inc);
    end
  end

  // one cursor step in a given direction, text wrap kept
  function automatic logic [AC_W-1:0] ac_nxt_dir(input logic right);
    logic [AC_W-1:0] a;
    a = ac_r;
    if (right) a = (ac_r == LINE1_LAST) ? LINE2_FIRST :
                   (ac_r == LINE2_LAST) ? LINE1_FIRST : 7'(ac_r + 7'h01);
    else a = (ac_r == LINE1_FIRST) ? LINE2_LAST :
             (ac_r == LINE2_FIRST) ? LINE1_LAST : 7'(ac_r - 7'h01);
    return a;
  endfunction : ac_nxt_dir

  // window offset; a left shift of the picture advances it
  function automatic logic [5:0] shift_step(input logic left);
    logic [5:0] s;
    if (left) s = (shift_r == 6'(LINE_COLS - 1)) ? 6'h00 : 6'(shift_r + 6'h01);
    else s = (shift_r == 6'h00) ? 6'(LINE_COLS - 1) : 6'(shift_r - 6'h01);
    return s;
  endfunction : shift_step

  // busy sequencer; clear walks the whole text store first
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r    <= ST_IDLE;
      busy_cnt_r <= '0;
      wipe_idx_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_ok && wbyte == 8'h01) begin
            state_r    <= ST_WIPE;
            busy_cnt_r <= BUSY_CNT_W'(CLEAR_CYC);
            wipe_idx_r <= 8'h00;
          end else if (cmd_ok || wr_ok) begin
            state_r    <= ST_EXEC;
            busy_cnt_r <= BUSY_CNT_W'(CMD_CYC);
          end
        end
        ST_WIPE: begin
          busy_cnt_r <= busy_cnt_r - 1'b1;
          wipe_idx_r <= wipe_idx_r + 8'h01;
          if (wipe_idx_r == 8'(DISP_BYTES - 1)) state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          busy_cnt_r <= busy_cnt_r - 1'b1;
          if (busy_cnt_r <= BUSY_CNT_W'(1)) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // memory writes; host writes and wipe never overlap (busy)
  always_ff @(posedge i_clk_sys) begin
    if (state_r == ST_WIPE) begin
      disp_mem[wipe_idx_r] <= BLANK_CHAR;
    end else if (wr_ok && sel_glyph_r) begin
      glyph_mem[ac_r[GLYPH_AW-1:0]] <= wbyte;
    end else if (wr_ok) begin
      disp_mem[disp_index(ac_r)] <= wbyte;
    end
  end

  // panel scan: rows 2/3 continue logical lines 1/2 after VIS_COLS
  assign scan_sum = 7'(i_scan_col) + (i_scan_row[1] ? 7'(VIS_COLS) : 7'h00)
                  + 7'(shift_r);
  assign scan_col = (scan_sum >= 7'(2 * LINE_COLS)) ?
                      7'(scan_sum - 7'(2 * LINE_COLS)) :
                    (scan_sum >= 7'(LINE_COLS)) ?
                      7'(scan_sum - 7'(LINE_COLS)) : scan_sum;
  // small font: 8 glyphs of 8 rows, bit 3 of code ignored
  assign glyph_addr = cfg_r.large_font ?
                        {scan_code_r[1:0], scan_row_r} :
                        {scan_code_r[2:0], scan_row_r[2:0]};

  // two-stage scan pipe: code first, pixels one cycle later
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      scan_code_r <= 8'h00;
      scan_row_r  <= 4'h0;
      scan_pix_r  <= 5'h00;
    end else begin
      scan_code_r <= disp_mem[disp_index({i_scan_row[0],
                                          scan_col[5:0]})];
      scan_row_r  <= i_scan_pix_row;
      scan_pix_r  <= (scan_code_r[7:4] == 4'h0) ?
                     glyph_mem[glyph_addr][4:0] : 5'h00;
    end
  end

  assign o_bus_data    = bus_out_r;
  assign o_bus_oe_n    = oe_n_r;
  assign o_scan_code   = scan_code_r;
  assign o_scan_pixels = scan_pix_r;
  assign o_disp_cfg    = cfg_r;
  assign o_cursor_addr = ac_r;

  // checks
  a_clear_home: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_ok && wbyte == 8'h01 |=> ac_r == 7'h00 && shift_r == 6'h00
      && state_r == ST_WIPE)
    else $error("clear did not home and start wipe");
  a_status_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    e_rise && p.rw && !p.register_select && cfg_r.bus_8bit
      |=> bus_out_r == {$past(busy), $past(ac_r)})
    else $error("status byte wrong");
  a_disp_ctrl: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_ok && wbyte[7:3] == 5'b00001
      |=> {cfg_r.display_on, cfg_r.cursor_on, cfg_r.blink_on}
          == $past(wbyte[2:0]))
    else $error("display control not applied");
  a_iface_fmt: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_ok && wbyte[7:5] == 3'b001
      |=> {cfg_r.bus_8bit, cfg_r.two_line, cfg_r.large_font}
          == $past(wbyte[4:2]))
    else $error("interface format not applied");
  a_glyph_sel: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_ok && wbyte[7:6] == 2'b01
      |=> sel_glyph_r && ac_r == {1'b0, $past(wbyte[5:0])})
    else $error("glyph address not loaded");
  a_text_sel: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_ok && wbyte[7] |=> !sel_glyph_r && ac_r == $past(wbyte[6:0]))
    else $error("text address not loaded");
  a_line_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    wr_ok && !sel_glyph_r && cfg_r.addr_inc && ac_r == LINE1_LAST
      |=> ac_r == LINE2_FIRST)
    else $error("line one did not wrap to line two");
  a_drive_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !oe_n_r |-> $past(p.e) && $past(p.rw))
    else $error("bus driven outside a read");
  a_wipe_len: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_r == ST_WIPE && wipe_idx_r == 8'(DISP_BYTES - 1) |=> state_r == ST_EXEC)
    else $error("wipe length wrong");
  a_busy_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    wr_ok |=> busy ##1 busy)
    else $error("no busy after data write");
  c_nibble_pair: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    done && !cfg_r.bus_8bit && acc_rs_r);
  c_clear: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_r == ST_WIPE ##1 state_r == ST_EXEC);
  c_glyph_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    wr_ok && sel_glyph_r);

endmodule : char_lcd_ctrl
`default_nettype wire

// ==== hw/char_lcd_pkg.sv ====
package char_lcd_pkg;

  // widths and memory sizes
  localparam int DATA_W        = 8;
  localparam int AC_W          = 7;
  localparam int GLYPH_AW      = 6;
  localparam int DISP_BYTES    = 160;
  localparam int GLYPH_BYTES   = 64;
  localparam int GLYPHS_SMALL  = 8;
  localparam int GLYPHS_LARGE  = 4;
  localparam int LINE_COLS     = 40;
  localparam int SYNC_STAGES   = 3;

  // text memory address map
  localparam logic [6:0] LINE1_FIRST = 7'h00;
  localparam logic [6:0] LINE1_LAST  = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST  = 7'h67;
  localparam logic [7:0] BLANK_CHAR  = 8'h20;

  // execution times, least times rounded up to clock cycles
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int CMD_EXEC_NS    = 40;
  localparam int CLEAR_EXEC_US  = 1520;
  localparam int CMD_EXEC_CYC   =
    (CMD_EXEC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLEAR_EXEC_CYC =
    (CLEAR_EXEC_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W     = 18;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WIPE = 3'b100
  } exec_state_t;

  // display configuration carried to the panel driver
  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic two_line;
    logic large_font;
    logic bus_8bit;
    logic addr_inc;
    logic shift_on;
  } disp_cfg_t;

  localparam disp_cfg_t CFG_RESET = 8'h06;

  // bus pins as seen after filtering
  typedef struct packed {
    logic                      e;
    logic                      register_select;
    logic                      rw;
    logic [DATA_W-1:0]         d;
  } bus_pins_t;

  // text memory index from a text address; line two starts 40 bytes on, column part not wrapped
  function automatic logic [7:0] disp_index(input logic [6:0] a);
    logic [7:0] col;
    col = {2'h0, a[5:0]};
    disp_index = a[6] ? 8'(col + 8'(LINE_COLS)) : col;
  endfunction : disp_index

endpackage : char_lcd_pkg

// ==== hw/pin_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_filter
  import char_lcd_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_pins,
  output var  logic [W-1:0] o_level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end else begin
      s1_r    <= i_pins;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    end
  end

  assign o_level = level_r;

endmodule : pin_filter
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe_n,
  output var  logic       o_e,
  output var  logic       o_rs,
  output var  logic       o_rw,
  output var  logic [7:0] o_wire,
  output var  logic       o_stuck
);
  logic       drv;
  logic [7:0] d_r;
  logic       four;

  // released bus shows the inverse of the last value, never a stale copy
  always_comb o_wire = drv ? d_r : (!i_dev_oe_n ? i_dev_data : ~d_r);

  initial begin
    o_e = 1'b0;
    o_rs = 1'b0;
    o_rw = 1'b1;
    drv = 1'b0;
    d_r = 8'h00;
    four = 1'b0;
    o_stuck = 1'b0;
  end

  // one strobe; pins settle 3 cycles before e and hold 8 after it
  task automatic strobe(input logic s, input logic w, input logic [7:0] v,
                        output logic [7:0] q);
    @(negedge i_clk_sys);
    o_rs = s;
    o_rw = w;
    d_r = v;
    drv = !w;
    repeat (3) @(negedge i_clk_sys);
    o_e = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    q = o_wire;
    @(negedge i_clk_sys);
    o_e = 1'b0;
    repeat (8) @(negedge i_clk_sys);
  endtask : strobe

  // one byte; narrow bus sends high nibble first on the upper lines
  task automatic xfer(input logic s, input logic w, input logic [7:0] v,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four) begin
      strobe(s, w, {v[7:4], 4'h0}, hi);
      strobe(s, w, {v[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      strobe(s, w, v, q);
    end
  endtask : xfer

  task automatic rd(input logic s, output logic [7:0] q);
    xfer(s, 1'b1, 8'h00, q);
  endtask : rd

  // poll status until idle, bounded, then write
  task automatic wr(input logic s, input logic [7:0] v);
    logic [7:0] st;
    int         n;
    n = 0;
    do begin
      rd(1'b0, st);
      n++;
    end while (st[7] !== 1'b0 && n < 100);
    if (st[7] !== 1'b0) o_stuck = 1'b1;
    xfer(s, 1'b0, v, st);
  endtask : wr
endmodule : host_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import char_lcd_pkg::*;
;
  localparam int VC = 20;
  logic            clk;
  logic            i_nrst;
  logic            e;
  logic            rs;
  logic            rw;
  logic [7:0]      wire_d;
  logic [7:0]      dev_d;
  logic            oe_n;
  logic            stuck;
  logic [1:0]      srow;
  logic [5:0]      scol;
  logic [3:0]      spix;
  logic [7:0]      scode;
  logic [4:0]      spixels;
  disp_cfg_t       cfg;
  logic [AC_W-1:0] ac;
  logic [7:0]      q;
  int              n_fail;
  int              n_compared;

  char_lcd_ctrl #(.VIS_COLS(VC), .CLEAR_CYC(300)) u_dut (
    .i_clk_sys(clk), .i_nrst(i_nrst), .i_e(e), .i_register_select(rs),
    .i_rw(rw), .i_bus_data(wire_d), .o_bus_data(dev_d), .o_bus_oe_n(oe_n),
    .i_scan_row(srow), .i_scan_col(scol), .i_scan_pix_row(spix),
    .o_scan_code(scode), .o_scan_pixels(spixels), .o_disp_cfg(cfg),
    .o_cursor_addr(ac));

  host_model u_host (
    .i_clk_sys(clk), .i_dev_data(dev_d), .i_dev_oe_n(oe_n), .o_e(e),
    .o_rs(rs), .o_rw(rw), .o_wire(wire_d), .o_stuck(stuck));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // a poll that never saw idle ends the run
  always @(posedge stuck) begin
    n_fail++;
    complete_run();
  end

  task automatic t_reset;
    check(cfg, CFG_RESET);
    check({1'b0, ac}, 8'h00);
    check({7'h0, oe_n}, 8'h01);
  endtask : t_reset

  // start-up: three wake-ups then narrow bus, then format with both fonts
  task automatic t_init;
    repeat (3) u_host.wr(1'b0, 8'h30);
    u_host.wr(1'b0, 8'h20);
    u_host.four = 1'b1;
    u_host.wr(1'b0, 8'h2C);
    check({5'h0, cfg.two_line, cfg.large_font, cfg.bus_8bit}, 8'h06);
    u_host.wr(1'b0, 8'h28);
    check({5'h0, cfg.two_line, cfg.large_font, cfg.bus_8bit}, 8'h04);
  endtask : t_init

  task automatic t_display;
    for (int v = 0; v < 8; v++) begin
      u_host.wr(1'b0, 8'h08 | 8'(v));
      check({5'h0, cfg.display_on, cfg.cursor_on, cfg.blink_on}, 8'(v));
    end
  endtask : t_display

  // clear is slow: status taken at once must still show busy
  task automatic t_clear;
    u_host.wr(1'b0, 8'h01);
    u_host.rd(1'b0, q);
    check({7'h0, q[7]}, 8'h01);
    u_host.wr(1'b0, 8'h80);
    u_host.rd(1'b1, q);
    check(q, BLANK_CHAR);
  endtask : t_clear

  task automatic t_text;
    u_host.wr(1'b0, 8'hC0);
    u_host.wr(1'b1, 8'h41);
    u_host.wr(1'b1, 8'h42);
    u_host.rd(1'b0, q);
    check(q, 8'h42);
    u_host.wr(1'b0, 8'hC0);
    u_host.rd(1'b1, q);
    check(q, 8'h41);
    u_host.wr(1'b0, 8'hA7);
    u_host.wr(1'b1, 8'h5A);
    u_host.rd(1'b0, q);
    check(q, 8'h40);
    u_host.wr(1'b0, 8'hE7);
    u_host.wr(1'b1, 8'h5B);
    u_host.rd(1'b0, q);
    check(q, 8'h00);
  endtask : t_text

  // decrement, cursor moves both ways, then home
  task automatic t_motion;
    u_host.wr(1'b0, 8'h04);
    u_host.wr(1'b0, 8'h85);
    u_host.wr(1'b1, 8'h33);
    u_host.rd(1'b0, q);
    check(q, 8'h04);
    u_host.wr(1'b0, 8'h14);
    u_host.rd(1'b0, q);
    check(q, 8'h05);
    u_host.wr(1'b0, 8'h10);
    u_host.rd(1'b0, q);
    check(q, 8'h04);
    u_host.wr(1'b0, 8'h06);
    u_host.wr(1'b0, 8'h02);
    u_host.rd(1'b0, q);
    check(q, 8'h00);
  endtask : t_motion

  task automatic scan(input logic [1:0] r, input logic [3:0] p);
    @(negedge clk);
    srow = r;
    scol = 6'h00;
    spix = p;
    repeat (4) @(negedge clk);
  endtask : scan

  // glyph 0 drawn as a letter, shown through code 08 with bit 3 ignored
  task automatic t_glyph;
    logic [7:0] rows [8];
    rows = '{8'h11, 8'h11, 8'h11, 8'h1F, 8'h11, 8'h11, 8'h11, 8'h00};
    u_host.wr(1'b0, 8'h40);
    for (int i = 0; i < 8; i++) u_host.wr(1'b1, rows[i]);
    u_host.wr(1'b0, 8'h43);
    u_host.rd(1'b1, q);
    check(q, rows[3]);
    u_host.wr(1'b0, 8'h80);
    u_host.wr(1'b1, 8'h08);
    u_host.wr(1'b0, 8'h80 | 8'(VC));
    u_host.wr(1'b1, 8'h55);
    scan(2'd0, 4'd3);
    check(scode, 8'h08);
    check({3'h0, spixels}, rows[3]);
    scan(2'd2, 4'd0);
    check(scode, 8'h55);
    // picture shift left by one: row three now starts one column later
    u_host.wr(1'b0, 8'h80 | 8'(VC + 1));
    u_host.wr(1'b1, 8'h56);
    u_host.wr(1'b0, 8'h18);
    scan(2'd2, 4'd0);
    check(scode, 8'h56);
  endtask : t_glyph

  initial begin
    n_fail = 0;
    n_compared = 0;
    i_nrst = 1'b0;
    srow = 2'd0;
    scol = 6'h00;
    spix = 4'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    t_reset();
    i_nrst = 1'b1;
    t_init();
    t_display();
    t_clear();
    t_text();
    t_motion();
    t_glyph();
    complete_run();
  end
endmodule : tb
`default_nettype wire
